//--- hdl/fmc_config_regs.sv
`timescale 1ns/1ps
module fmc_config_regs
   import fmc_pkg::*;
#(
   parameter int MEAS_SLOW_CYC_P = MEAS_SLOW_CYC,
   parameter int MEAS_FAST_CYC_P = MEAS_FAST_CYC
) (
   input  wire logic       sys_clk_i,
   input  wire logic       sys_rst_i,
   // Register access port
   input  wire logic [7:0] reg_addr_i,
   input  wire logic       reg_wr_i,
   input  wire logic [7:0] reg_wdata_i,
   input  wire logic       reg_rd_i,
   output logic      [7:0] reg_rdata_o,
   // Device-wide lock and software reset
   input  wire logic       lock_i,
   input  wire logic       sw_reset_i,
   // Regulator alert inputs
   input  wire logic       regulator_alert_one_i,
   input  wire logic       regulator_alert_two_i,
   // Fan and measurement controls
   output logic            fast_measure_o,
   output logic            high_freq_mode_o,
   output logic            regulator_one_boost_disable_o,
   output logic            regulator_two_boost_disable_o,
   output logic            fan_full_speed_o,
   output logic      [2:0] speed_pulse_count_o,
   output logic            measure_tick_o,
   // Miscellaneous controls
   output logic            gpio_enable_o,
   output logic            scl_timeout_en_o,
   output logic            sda_timeout_en_o,
   output logic            ident_input_low_thresh_o,
   output logic            thermal_input_low_thresh_o,
   output logic            intrusion_clear_o,
   output logic            xor_tree_test_o,
   output logic            low_core_mode_o,
   // Tachometer controls
   output logic      [7:0] speed_input_enable_o,
   output logic      [7:0] continuous_enable_o
);
   typedef struct packed {
      logic [7:0]            cfg_a;
      logic [7:0]            cfg_b;
      logic [7:0]            tach_en;
      logic [TACH_CFG_W-1:0] tach_cfg;
      logic [7:0]            rdata;
      logic                  full_spd;
      logic                  intr_clr;
      logic [7:0]            cont_en;
      logic [2:0]            pcnt;
      logic [TICK_W-1:0]     gap;
      logic                  seen;
      logic                  rate_chg;
   } fmc_cfg_st_t;

   localparam fmc_cfg_st_t RST_ST = '{
      cfg_a:    RST_CFG_A,
      cfg_b:    RST_CFG_B,
      tach_en:  RST_TACH_EN,
      tach_cfg: RST_TACH_CFG,
      rdata:    RDATA_NONE,
      full_spd: 1'b0,
      intr_clr: 1'b0,
      cont_en:  8'h00,
      pcnt:     RST_CFG_A[A_PCNT_HI:A_PCNT_LO] + PCNT_OFFSET,
      gap:      '0,
      seen:     1'b0,
      rate_chg: 1'b0
   };

   localparam logic [TICK_W-1:0] SLOW_PER = TICK_W'(MEAS_SLOW_CYC_P);
   localparam logic [TICK_W-1:0] FAST_PER = TICK_W'(MEAS_FAST_CYC_P);

   fmc_cfg_st_t       st_r;
   fmc_cfg_st_t       st_nxt;
   logic              wr_ok;
   logic              tick;
   logic [TICK_W-1:0] meas_period;

   // Writes and software reset only land while unlocked
   assign wr_ok = reg_wr_i & ~lock_i;

   // Fast bit picks the shorter measurement period
   assign meas_period = st_r.cfg_a[A_FAST] ? FAST_PER : SLOW_PER;

   // Measurement tick runs only in low-frequency drive mode
   fmc_tick_gen #(
      .CW        (TICK_W)
   ) u_tick (
      .sys_clk_i (sys_clk_i),
      .sys_rst_i (sys_rst_i),
      .run_i     (~st_r.cfg_a[A_HF_MODE]),
      .period_i  (meas_period),
      .tick_o    (tick)
   );

   // Next-state logic for registers and derived controls
   always_comb begin
      st_nxt = st_r;
      st_nxt.intr_clr = 1'b0;
      // Software reset restores defaults unless locked
      if (sw_reset_i && !lock_i) begin
         st_nxt.cfg_a    = RST_CFG_A;
         st_nxt.cfg_b    = RST_CFG_B;
         st_nxt.tach_en  = RST_TACH_EN;
         st_nxt.tach_cfg = RST_TACH_CFG;
      end
      // Register writes, a same-cycle write overrides the reset
      if (wr_ok) begin
         case (reg_addr_i)
            ADDR_CFG_A: begin
               st_nxt.cfg_a = reg_wdata_i;
            end
            ADDR_CFG_B: begin
               st_nxt.cfg_b = reg_wdata_i;
               st_nxt.cfg_b[B_INTR_CLR] = 1'b0;
               st_nxt.intr_clr = reg_wdata_i[B_INTR_CLR];
            end
            ADDR_TACH_EN: begin
               st_nxt.tach_en = reg_wdata_i;
            end
            ADDR_TACH_CFG: begin
               st_nxt.tach_cfg = reg_wdata_i[TACH_CFG_W-1:0];
            end
            default: begin
               st_nxt.intr_clr = 1'b0;
            end
         endcase
      end
      // Read data captured on a read strobe, unmapped reads give zero
      if (reg_rd_i) begin
         case (reg_addr_i)
            ADDR_CFG_A: begin
               st_nxt.rdata = st_r.cfg_a;
            end
            ADDR_CFG_B: begin
               st_nxt.rdata = st_r.cfg_b;
            end
            ADDR_TACH_EN: begin
               st_nxt.rdata = st_r.tach_en;
            end
            ADDR_TACH_CFG: begin
               st_nxt.rdata = {{(8-TACH_CFG_W){1'b0}}, st_r.tach_cfg};
            end
            default: begin
               st_nxt.rdata = RDATA_NONE;
            end
         endcase
      end
      // Full speed from force bit or an enabled regulator alert
      st_nxt.full_spd = st_r.cfg_a[A_FORCE_FULL]
         | (regulator_alert_one_i & ~st_r.cfg_a[A_BOOST1_DIS])
         | (regulator_alert_two_i & ~st_r.cfg_a[A_BOOST2_DIS]);
      // Continuous measurement only in low-frequency mode, bit k feeds channels k and k+4
      st_nxt.cont_en = st_r.cfg_a[A_HF_MODE] ? 8'h00
                       : {st_r.tach_cfg, st_r.tach_cfg};
      // Timed pulse count is the field value plus one
      st_nxt.pcnt = {1'b0, st_r.cfg_a[A_PCNT_HI:A_PCNT_LO]} + PCNT_OFFSET;
      // Assertion helper: cycles since the last tick, and any rate change meanwhile
      if (st_r.cfg_a[A_HF_MODE] || tick) begin
         st_nxt.gap      = '0;
         st_nxt.seen     = tick;
         st_nxt.rate_chg = 1'b0;
      end else begin
         st_nxt.gap      = st_r.gap + {{(TICK_W-1){1'b0}}, 1'b1};
         st_nxt.rate_chg = st_r.rate_chg | (st_nxt.cfg_a[A_FAST] != st_r.cfg_a[A_FAST]);
      end
   end

   // State register
   always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         st_r <= RST_ST;
      end else begin
         st_r <= st_nxt;
      end
   end

   // Outputs taken straight from state flops
   assign reg_rdata_o                   = st_r.rdata;
   assign fast_measure_o                = st_r.cfg_a[A_FAST];
   assign high_freq_mode_o              = st_r.cfg_a[A_HF_MODE];
   assign regulator_one_boost_disable_o = st_r.cfg_a[A_BOOST1_DIS];
   assign regulator_two_boost_disable_o = st_r.cfg_a[A_BOOST2_DIS];
   assign fan_full_speed_o              = st_r.full_spd;
   assign speed_pulse_count_o           = st_r.pcnt;
   assign measure_tick_o                = tick;
   assign gpio_enable_o                 = st_r.cfg_b[B_GPIO_EN];
   assign scl_timeout_en_o              = st_r.cfg_b[B_SCL_TO];
   assign sda_timeout_en_o              = st_r.cfg_b[B_SDA_TO];
   assign ident_input_low_thresh_o      = st_r.cfg_b[B_IDENT_LOW];
   assign thermal_input_low_thresh_o    = st_r.cfg_b[B_THERM_LOW];
   assign intrusion_clear_o             = st_r.intr_clr;
   assign xor_tree_test_o               = st_r.cfg_b[B_XOR_TREE];
   assign low_core_mode_o               = st_r.cfg_b[B_LOW_CORE];
   assign speed_input_enable_o          = st_r.tach_en;
   assign continuous_enable_o           = st_r.cont_en;

   // Checks on rate, mode, registers and derived controls
   default clocking cb @(posedge sys_clk_i);
   endclocking
   default disable iff (sys_rst_i);

   chk_tick_gap: assert property (
      tick && st_r.seen && !st_r.rate_chg |-> st_r.gap == meas_period - {{(TICK_W-1){1'b0}}, 1'b1})
      else $error("measurement tick spacing wrong");

   chk_tick_lf_only: assert property (
      st_r.cfg_a[A_HF_MODE] |=> !measure_tick_o)
      else $error("measurement tick in high frequency mode");

   chk_boost_one: assert property (
      regulator_alert_one_i && !regulator_one_boost_disable_o |=> fan_full_speed_o)
      else $error("first regulator alert did not force full speed");

   chk_boost_two: assert property (
      regulator_alert_two_i && !regulator_two_boost_disable_o |=> fan_full_speed_o)
      else $error("second regulator alert did not force full speed");

   chk_full_cause: assert property (
      fan_full_speed_o |-> $past(st_r.cfg_a[A_FORCE_FULL])
         || ($past(regulator_alert_one_i) && !$past(regulator_one_boost_disable_o))
         || ($past(regulator_alert_two_i) && !$past(regulator_two_boost_disable_o)))
      else $error("full speed without cause");

   chk_pulse_count: assert property (
      wr_ok && reg_addr_i == ADDR_CFG_A
         |=> ##1 speed_pulse_count_o == {1'b0, $past(reg_wdata_i[A_PCNT_HI:A_PCNT_LO], 2)}
            + PCNT_OFFSET)
      else $error("pulse count does not follow written field");

   chk_clear_pulse: assert property (
      wr_ok && reg_addr_i == ADDR_CFG_B && reg_wdata_i[B_INTR_CLR]
         |=> intrusion_clear_o && !st_r.cfg_b[B_INTR_CLR]
            ##1 (!intrusion_clear_o
                 || $past(wr_ok && reg_addr_i == ADDR_CFG_B && reg_wdata_i[B_INTR_CLR])))
      else $error("intrusion clear not a single self-clearing pulse");

   chk_lock_hold: assert property (
      lock_i |=> $stable({st_r.cfg_a, st_r.cfg_b, st_r.tach_en, st_r.tach_cfg}))
      else $error("locked register changed");

   chk_swrst_default: assert property (
      sw_reset_i && !lock_i && !reg_wr_i
         |=> st_r.cfg_a == RST_CFG_A && st_r.tach_en == RST_TACH_EN)
      else $error("software reset did not restore defaults");

   chk_resv_zero: assert property (
      reg_rd_i && reg_addr_i == ADDR_TACH_CFG |=> reg_rdata_o[7:TACH_CFG_W] == 4'h0)
      else $error("reserved tachometer bits read nonzero");

   chk_cont_pair: assert property (
      !high_freq_mode_o
         |=> continuous_enable_o[3:0] == $past(st_r.tach_cfg)
            && continuous_enable_o[7:4] == $past(st_r.tach_cfg))
      else $error("continuous enable pairs differ");

   chk_cont_hf_zero: assert property (
      high_freq_mode_o |=> continuous_enable_o == '0)
      else $error("continuous enable set in high frequency mode");

   // Register writes reach their controls
   chk_cfg_a_write: assert property (
      wr_ok && reg_addr_i == ADDR_CFG_A |=> st_r.cfg_a == $past(reg_wdata_i))
      else $error("first register did not take written value");

   chk_fast_bit: assert property (
      wr_ok && reg_addr_i == ADDR_CFG_A |=> fast_measure_o == $past(reg_wdata_i[A_FAST]))
      else $error("fast measure bit does not follow write");

   chk_hf_mode: assert property (
      wr_ok && reg_addr_i == ADDR_CFG_A |=> high_freq_mode_o == $past(reg_wdata_i[A_HF_MODE]))
      else $error("drive mode does not follow written bit");

   chk_force_full: assert property (
      st_r.cfg_a[A_FORCE_FULL] |=> fan_full_speed_o)
      else $error("force bit did not give full speed");

   chk_cfg_b_write: assert property (
      wr_ok && reg_addr_i == ADDR_CFG_B
         |=> {low_core_mode_o, xor_tree_test_o} == $past(reg_wdata_i[B_LOW_CORE:B_XOR_TREE])
            && {thermal_input_low_thresh_o, ident_input_low_thresh_o, sda_timeout_en_o,
                scl_timeout_en_o, gpio_enable_o} == $past(reg_wdata_i[B_THERM_LOW:B_GPIO_EN]))
      else $error("second register controls do not follow write");

   chk_tach_enable: assert property (
      wr_ok && reg_addr_i == ADDR_TACH_EN |=> speed_input_enable_o == $past(reg_wdata_i))
      else $error("tachometer enables do not follow write");

   // Read-back and lock behaviour
   chk_intr_bit_zero: assert property (
      reg_rd_i && reg_addr_i == ADDR_CFG_B |=> !reg_rdata_o[B_INTR_CLR])
      else $error("intrusion clear bit read back as one");

   chk_read_cfg_a: assert property (
      reg_rd_i && reg_addr_i == ADDR_CFG_A |=> reg_rdata_o == $past(st_r.cfg_a))
      else $error("first register read data wrong");

   chk_read_tach_en: assert property (
      reg_rd_i && reg_addr_i == ADDR_TACH_EN |=> reg_rdata_o == $past(st_r.tach_en))
      else $error("tachometer enable read data wrong");

   chk_lock_no_clear: assert property (
      lock_i |=> !intrusion_clear_o)
      else $error("intrusion clear pulse while locked");

   chk_swrst_misc: assert property (
      sw_reset_i && !lock_i && !reg_wr_i
         |=> st_r.cfg_b == RST_CFG_B && st_r.tach_cfg == RST_TACH_CFG)
      else $error("software reset did not restore second and config registers");

   cov_full_alert: cover property (
      regulator_alert_one_i ##1 fan_full_speed_o);
   cov_intr_clear: cover property (
      intrusion_clear_o);
   cov_locked_write: cover property (
      reg_wr_i && lock_i);
   cov_swrst: cover property (
      sw_reset_i && !lock_i);
   cov_fast_tick: cover property (
      measure_tick_o && fast_measure_o);
endmodule

//--- hdl/fmc_pkg.sv
package fmc_pkg;
   // Register offsets
   localparam logic [7:0] ADDR_CFG_A    = 8'h02;
   localparam logic [7:0] ADDR_CFG_B    = 8'h03;
   localparam logic [7:0] ADDR_TACH_EN  = 8'h07;
   localparam logic [7:0] ADDR_TACH_CFG = 8'h08;
   // Reset values
   localparam logic [7:0] RST_CFG_A     = 8'h40;
   localparam logic [7:0] RST_CFG_B     = 8'h00;
   localparam logic [7:0] RST_TACH_EN   = 8'h00;
   localparam logic [3:0] RST_TACH_CFG  = 4'h0;
   localparam logic [7:0] RDATA_NONE    = 8'h00;
   // First register fields
   localparam int         A_FAST        = 0;
   localparam int         A_HF_MODE     = 2;
   localparam int         A_BOOST1_DIS  = 3;
   localparam int         A_BOOST2_DIS  = 4;
   localparam int         A_FORCE_FULL  = 5;
   localparam int         A_PCNT_LO     = 6;
   localparam int         A_PCNT_HI     = 7;
   localparam logic [2:0] PCNT_OFFSET   = 3'h1;
   // Second register fields
   localparam int         B_GPIO_EN     = 0;
   localparam int         B_SCL_TO      = 1;
   localparam int         B_SDA_TO      = 2;
   localparam int         B_IDENT_LOW   = 3;
   localparam int         B_THERM_LOW   = 4;
   localparam int         B_INTR_CLR    = 5;
   localparam int         B_XOR_TREE    = 6;
   localparam int         B_LOW_CORE    = 7;
   // Tachometer configuration width
   localparam int         TACH_CFG_W    = 4;
   // Measurement rate timing
   localparam int         CLK_PERIOD_NS = 25;
   localparam int         NS_PER_MS     = 1000000;
   localparam int         MEAS_SLOW_MS  = 1000;
   localparam int         MEAS_FAST_MS  = 250;
   localparam int         MEAS_SLOW_CYC = MEAS_SLOW_MS * (NS_PER_MS / CLK_PERIOD_NS);
   localparam int         MEAS_FAST_CYC = MEAS_FAST_MS * (NS_PER_MS / CLK_PERIOD_NS);
   localparam int         TICK_W        = 26;
endpackage

//--- hdl/fmc_tick_gen.sv
`timescale 1ns/1ps
module fmc_tick_gen #(
   parameter int CW = 26
) (
   input  wire logic          sys_clk_i,
   input  wire logic          sys_rst_i,
   input  wire logic          run_i,
   input  wire logic [CW-1:0] period_i,
   output logic               tick_o
);
   typedef struct packed {
      logic [CW-1:0] cnt;
      logic          tick;
   } fmc_tick_st_t;

   fmc_tick_st_t st_r;
   fmc_tick_st_t st_nxt;

   // Count up to period minus one, then pulse for one cycle
   always_comb begin
      st_nxt = st_r;
      st_nxt.tick = 1'b0;
      if (!run_i) begin
         st_nxt.cnt = '0;
      end else if (st_r.cnt >= period_i - {{(CW-1){1'b0}}, 1'b1}) begin
         st_nxt.cnt = '0;
         st_nxt.tick = 1'b1;
      end else begin
         st_nxt.cnt = st_r.cnt + {{(CW-1){1'b0}}, 1'b1};
      end
   end

   // State register
   always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign tick_o = st_r.tick;
endmodule

//--- sim/fan_monitor_config_registers_test.sv
`timescale 1ns/1ps
module fan_monitor_config_registers_test;
   import fmc_pkg::*;
   typedef struct packed {logic [7:0] addr; logic [7:0] wdata; logic [7:0] exp;} fmc_row_t;
   logic       sys_clk_i, sys_rst_i, lock_i, sw_reset, alert1, alert2, wr, rd_stb;
   logic [7:0] addr, wdata, rdata, rd;
   logic       fast, hf, b1_dis, b2_dis, full, tick, gpio, scl, sda, ident, therm, intr;
   logic       xor_t, low_core;
   logic [2:0] pcnt;
   logic [7:0] spd_en, cont_en;
   int         error_cnt, compares, cycles, n;
   fmc_row_t   rows [7];

   fmc_config_regs #(.MEAS_SLOW_CYC_P(40), .MEAS_FAST_CYC_P(10)) DUT (
      .sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i), .reg_addr_i(addr), .reg_wr_i(wr),
      .reg_wdata_i(wdata), .reg_rd_i(rd_stb), .reg_rdata_o(rdata), .lock_i(lock_i),
      .sw_reset_i(sw_reset), .regulator_alert_one_i(alert1), .regulator_alert_two_i(alert2),
      .fast_measure_o(fast), .high_freq_mode_o(hf), .regulator_one_boost_disable_o(b1_dis),
      .regulator_two_boost_disable_o(b2_dis), .fan_full_speed_o(full),
      .speed_pulse_count_o(pcnt), .measure_tick_o(tick), .gpio_enable_o(gpio),
      .scl_timeout_en_o(scl), .sda_timeout_en_o(sda), .ident_input_low_thresh_o(ident),
      .thermal_input_low_thresh_o(therm), .intrusion_clear_o(intr), .xor_tree_test_o(xor_t),
      .low_core_mode_o(low_core), .speed_input_enable_o(spd_en), .continuous_enable_o(cont_en));

   fmc_host_model host (
      .sys_clk_i(sys_clk_i), .reg_addr_o(addr), .reg_wr_o(wr), .reg_wdata_o(wdata),
      .reg_rd_o(rd_stb), .reg_rdata_i(rdata), .sw_reset_o(sw_reset));

   // Clock at 40 MHz
   always #12.5 sys_clk_i = ~sys_clk_i;

   // Cut a hung run short
   always @(posedge sys_clk_i) begin
      cycles++;
      if (cycles == 20000) begin
         error_cnt++;
         complete_run();
      end
   end

   task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
      compares++;
      if (seen !== exp) begin
         error_cnt++;
         $display("wrong value %s expected %h seen %h", name, exp, seen);
      end
   endtask

   task automatic complete_run();
      $display("compares %0d error_cnt %0d", compares, error_cnt);
      if (error_cnt == 0 && compares > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask

   // Alert levels and boost bits against the full-speed output
   task automatic full_chk(input logic a1, input logic a2, input logic [7:0] cfg,
                           input logic exp);
      alert1 = a1;
      alert2 = a2;
      host.write_reg(ADDR_CFG_A, cfg);
      repeat (2) @(negedge sys_clk_i);
      check("full speed", {7'h00, full}, {7'h00, exp});
      check("boost disables", {6'h00, b2_dis, b1_dis}, {6'h00, cfg[4:3]});
   endtask

   // Cycles until the next measurement tick, 200 when none comes
   task automatic wait_tick(output int cnt);
      cnt = 0;
      do begin
         @(negedge sys_clk_i);
         cnt++;
      end while (tick !== 1'b1 && cnt < 200);
   endtask

   initial begin
      sys_clk_i = 1'b0;
      sys_rst_i = 1'b1;
      lock_i    = 1'b0;
      alert1    = 1'b0;
      alert2    = 1'b0;
      rows = '{{8'h02, 8'h21, 8'h21}, {8'h02, 8'hc4, 8'hc4}, {8'h03, 8'hff, 8'hdf},
               {8'h07, 8'ha5, 8'ha5}, {8'h08, 8'hff, 8'h0f}, {8'h05, 8'hff, 8'h00},
               {8'h7b, 8'h6d, 8'h00}};
      repeat (8) @(posedge sys_clk_i);
      @(negedge sys_clk_i);
      sys_rst_i = 1'b0;
      // Reset values of every register and the pulse count
      host.read_reg(ADDR_CFG_A, rd);
      check("cfg a reset", rd, RST_CFG_A);
      host.read_reg(ADDR_CFG_B, rd);
      check("cfg b reset", rd, 8'h00);
      host.read_reg(ADDR_TACH_EN, rd);
      check("tach en reset", rd, 8'h00);
      host.read_reg(ADDR_TACH_CFG, rd);
      check("tach cfg reset", rd, 8'h00);
      check("pulse count reset", {5'h00, pcnt}, 8'h02);
      // Ordinary write and read-back rows
      for (int i = 0; i < 7; i++) begin
         host.write_reg(rows[i].addr, rows[i].wdata);
         host.read_reg(rows[i].addr, rd);
         check("readback", rd, rows[i].exp);
      end
      // Second register fields and tachometer enables
      check("cfg b low", {4'h0, ident, sda, scl, gpio}, 8'h0f);
      check("cfg b high", {5'h00, low_core, xor_t, therm}, 8'h07);
      check("speed enables", spd_en, 8'ha5);
      check("hf mode", {7'h00, hf}, 8'h01);
      check("continuous hf", cont_en, 8'h00);
      // Every pulse count code
      for (int c = 0; c < 4; c++) begin
         host.write_reg(ADDR_CFG_A, {c[1:0], 6'h00});
         repeat (2) @(negedge sys_clk_i);
         check("pulse count", {5'h00, pcnt}, 8'(c + 1));
      end
      check("continuous lf", cont_en, 8'hff);
      host.write_reg(ADDR_TACH_CFG, 8'h05);
      repeat (2) @(negedge sys_clk_i);
      check("continuous pairs", cont_en, 8'h55);
      // Regulator alerts, boost disables and forced full speed
      full_chk(1'b1, 1'b0, 8'h00, 1'b1);
      full_chk(1'b1, 1'b0, 8'h08, 1'b0);
      full_chk(1'b0, 1'b1, 8'h08, 1'b1);
      full_chk(1'b0, 1'b1, 8'h10, 1'b0);
      full_chk(1'b0, 1'b0, 8'h20, 1'b1);
      // Intrusion clear write gives a single pulse on the output
      host.write_reg(ADDR_CFG_B, 8'h20);
      n = 0;
      repeat (4) begin
         n += intr;
         @(negedge sys_clk_i);
      end
      check("intrusion pulses", 8'(n), 8'h01);
      // Measurement tick periods, slow then fast, none in hf mode
      host.write_reg(ADDR_CFG_A, 8'h00);
      wait_tick(n);
      wait_tick(n);
      check("slow period", 8'(n), 8'd40);
      host.write_reg(ADDR_CFG_A, 8'h01);
      check("fast bit", {7'h00, fast}, 8'h01);
      wait_tick(n);
      wait_tick(n);
      check("fast period", 8'(n), 8'd10);
      host.write_reg(ADDR_CFG_A, 8'h04);
      wait_tick(n);
      check("no tick in hf", 8'(n), 8'd200);
      // Locked registers ignore writes and software reset
      host.write_reg(ADDR_CFG_A, 8'h01);
      lock_i = 1'b1;
      host.write_reg(ADDR_CFG_A, 8'hff);
      host.write_unlock(8'h6d);
      host.soft_reset();
      host.read_reg(ADDR_CFG_A, rd);
      check("locked cfg a", rd, 8'h01);
      host.write_reg(ADDR_CFG_B, 8'h20);
      check("locked intrusion", {7'h00, intr}, 8'h00);
      // Unlocked software reset restores defaults
      lock_i = 1'b0;
      host.write_unlock(8'h6d);
      host.soft_reset();
      host.read_reg(ADDR_CFG_A, rd);
      check("sw reset cfg a", rd, RST_CFG_A);
      host.read_reg(ADDR_TACH_EN, rd);
      check("sw reset tach en", rd, 8'h00);
      // Mid-run reset drops forced full speed and restores defaults
      host.write_reg(ADDR_CFG_A, 8'h20);
      @(negedge sys_clk_i);
      sys_rst_i = 1'b1;
      repeat (2) @(negedge sys_clk_i);
      sys_rst_i = 1'b0;
      host.read_reg(ADDR_CFG_A, rd);
      check("cfg a mid reset", rd, RST_CFG_A);
      check("full speed mid reset", {7'h00, full}, 8'h00);
      check("pulse count mid reset", {5'h00, pcnt}, 8'h02);
      complete_run();
   end
endmodule

//--- sim/fmc_host_model.sv
`timescale 1ns/1ps
module fmc_host_model (
   input  wire logic       sys_clk_i,
   output logic      [7:0] reg_addr_o,
   output logic            reg_wr_o,
   output logic      [7:0] reg_wdata_o,
   output logic            reg_rd_o,
   input  wire logic [7:0] reg_rdata_i,
   output logic            sw_reset_o
);
   localparam logic [7:0] UNLOCK_ADDR = 8'h7b;
   logic [7:0]            unlock_r;

   // Idle request lines from time zero
   initial begin
      reg_addr_o  = 8'h00;
      reg_wr_o    = 1'b0;
      reg_wdata_o = 8'h00;
      reg_rd_o    = 1'b0;
      sw_reset_o  = 1'b0;
      unlock_r    = 8'h00;
   end

   // One-cycle write strobe launched off the falling edge
   task automatic write_reg(input logic [7:0] addr, input logic [7:0] data);
      @(negedge sys_clk_i);
      reg_addr_o  = addr;
      reg_wdata_o = data;
      reg_wr_o    = 1'b1;
      @(negedge sys_clk_i);
      reg_wr_o    = 1'b0;
      reg_wdata_o = ~data;  // Released data does not keep its last value
   endtask

   // Read strobe, then take the data once it has settled
   task automatic read_reg(input logic [7:0] addr, output logic [7:0] data);
      @(negedge sys_clk_i);
      reg_addr_o = addr;
      reg_rd_o   = 1'b1;
      @(negedge sys_clk_i);
      reg_rd_o   = 1'b0;
      @(negedge sys_clk_i);
      data       = reg_rdata_i;
   endtask

   // Unlock code goes out as a bus write to the unlock register first
   task automatic write_unlock(input logic [7:0] code);
      write_reg(UNLOCK_ADDR, code);
      unlock_r = code;
   endtask

   // Software reset is only requested after the correct unlock code
   task automatic soft_reset();
      @(negedge sys_clk_i);
      sw_reset_o = (unlock_r == 8'h6d);
      @(negedge sys_clk_i);
      sw_reset_o = 1'b0;
      unlock_r   = 8'h00;
   endtask
endmodule
